// ==== rtl/fwsp_top.sv ====
/*
  four-wire serial port: control/data registers on AXI4-Lite, master and slave engine.
  assumes pins synchronous to clk; the pad layer resolves the active-low enables.
*/
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module fwsp_top #(
  parameter bit CFG_PORT_FUNC = 1'b1,
  parameter bit CFG_SEL_PIN   = 1'b1,
  parameter bit CFG_WCOL      = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sub_clock_tick,
  input  wire logic        timer_period_match,
  input  wire logic        serial_input_line,
  output logic             serial_output_line,
  output logic             serial_output_oe_n,
  input  wire logic        serial_clock_in,
  output logic             serial_clock_out,
  output logic             serial_clock_oe_n,
  input  wire logic        slave_select_in_n,
  output logic             slave_select_out_n,
  output logic             slave_select_oe_n
);

  // ==========================================================
  // registers
  fwsp_pkg::fwsp_ctl0_t ctl0_r;
  fwsp_pkg::fwsp_ctl1_t ctl1_r;
  logic [7:0]           data_r;
  logic [7:0]           tx_sh_r;
  logic [7:0]           rx_sh_r;
  logic [4:0]           edge_cnt_r;
  logic                 m_busy_r;
  logic                 sck_r;
  logic                 sck_in_d_r;
  logic                 aw_ok_r;
  logic                 w_ok_r;
  logic [3:0]           aw_addr_r;
  logic [7:0]           w_byte_r;
  logic                 w_lane_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 rvalid_r;
  logic [7:0]           rdata_r;
  logic [1:0]           rresp_r;

  // ==========================================================
  // bus decode
  logic       aw_take;
  logic       w_take;
  logic       do_wr;
  logic       wr_ctl0;
  logic       wr_ctl1;
  logic       wr_data;
  logic       wr_hit;
  logic       ar_take;
  logic       rd_hit;
  logic [7:0] ctl0_rd;
  logic [7:0] ctl1_rd;
  logic [7:0] rd_mux;

  assign s_axi_awready = !aw_ok_r && !bvalid_r;
  assign s_axi_wready  = !w_ok_r && !bvalid_r;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_wr         = aw_ok_r && w_ok_r && !bvalid_r;
  assign wr_hit        = (aw_addr_r == fwsp_pkg::OFS_CONTROL_0) ||
                         (aw_addr_r == fwsp_pkg::OFS_CONTROL_1) ||
                         (aw_addr_r == fwsp_pkg::OFS_DATA_BUFFER);
  assign wr_ctl0       = do_wr && w_lane_r && (aw_addr_r == fwsp_pkg::OFS_CONTROL_0);
  assign wr_ctl1       = do_wr && w_lane_r && (aw_addr_r == fwsp_pkg::OFS_CONTROL_1);
  assign wr_data       = do_wr && w_lane_r && (aw_addr_r == fwsp_pkg::OFS_DATA_BUFFER);

  assign s_axi_arready = !rvalid_r;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_hit        = (s_axi_araddr == fwsp_pkg::OFS_CONTROL_0) ||
                         (s_axi_araddr == fwsp_pkg::OFS_CONTROL_1) ||
                         (s_axi_araddr == fwsp_pkg::OFS_DATA_BUFFER);
  assign ctl0_rd       = {ctl0_r.clock_source_select, 3'h0,
                          ctl0_r.port_enable_bit, 1'b0};
  assign ctl1_rd       = {2'h0, ctl1_r};
  assign rd_mux        = (s_axi_araddr == fwsp_pkg::OFS_CONTROL_0) ? ctl0_rd :
                         (s_axi_araddr == fwsp_pkg::OFS_CONTROL_1) ? ctl1_rd :
                         (s_axi_araddr == fwsp_pkg::OFS_DATA_BUFFER) ? data_r : 8'h00;

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = {24'h000000, rdata_r};

  // ==========================================================
  // mode decode
  logic       en;
  logic       is_master;
  logic       is_slave;
  logic       sel_en;
  logic       selected;
  logic       idle_lvl;
  logic       busy;
  logic       m_start;
  logic       half_tick;
  logic       s_edge;
  logic       sck_edge;
  logic       lead;
  logic       capture;
  logic       last_edge;
  logic       tx_bit;
  logic [7:0] rx_shifted;
  logic [7:0] tx_shifted;

  // the enable bit is void unless the pins are given to the port
  assign en        = CFG_PORT_FUNC && ctl0_r.port_enable_bit;
  assign is_master = en && (ctl0_r.clock_source_select < fwsp_pkg::SRC_SLAVE);
  assign is_slave  = en && (ctl0_r.clock_source_select == fwsp_pkg::SRC_SLAVE);
  assign sel_en    = CFG_SEL_PIN && ctl1_r.select_pin_enable;
  assign selected  = sel_en ? !slave_select_in_n : 1'b1;
  assign idle_lvl  = !ctl1_r.clock_idle_polarity;
  assign busy      = m_busy_r || (edge_cnt_r != 5'h00);
  assign m_start   = wr_data && is_master && !busy;

  fwsp_rate_gen u_rate (
    .clk                (clk),
    .rst_n              (rst_n),
    .run                (m_busy_r && is_master),
    .src                (ctl0_r.clock_source_select),
    .sub_clock_tick     (sub_clock_tick),
    .timer_period_match (timer_period_match),
    .half_tick          (half_tick)
  );

  // slave edges only count while selected; idle-mode has no effect here
  assign s_edge    = is_slave && selected && (serial_clock_in != sck_in_d_r);
  assign sck_edge  = (m_busy_r && is_master && half_tick) || s_edge;
  // even edge numbers leave the idle level, odd ones return to it
  assign lead      = !edge_cnt_r[0];
  // the edge bit alone says leading or trailing for either polarity
  assign capture   = (lead == ctl1_r.clock_edge_select);
  assign last_edge = sck_edge && (edge_cnt_r == fwsp_pkg::EDGES_PER_XFER - 5'h01);
  assign tx_bit    = ctl1_r.bit_order_select ? tx_sh_r[7] : tx_sh_r[0];
  assign rx_shifted = ctl1_r.bit_order_select ? {rx_sh_r[6:0], serial_input_line} :
                                                {serial_input_line, rx_sh_r[7:1]};
  assign tx_shifted = ctl1_r.bit_order_select ? {tx_sh_r[6:0], 1'b0} :
                                                {1'b0, tx_sh_r[7:1]};

  // ==========================================================
  // pins
  assign serial_clock_out   = sck_r;
  assign serial_clock_oe_n  = !is_master;
  assign serial_output_line = tx_bit;
  assign serial_output_oe_n = !(is_master || (is_slave && selected));
  // select line floats unless enabled in master mode; master pulls it low for the frame
  assign slave_select_out_n = !m_busy_r;
  assign slave_select_oe_n  = !(is_master && sel_en);

  // ==========================================================
  // next values
  logic [7:0]           data_nxt;
  fwsp_pkg::fwsp_ctl1_t ctl1_nxt;
  logic                 done_set;
  logic                 wcol_set;

  assign done_set = last_edge;
  assign wcol_set = CFG_WCOL && wr_data && busy;
  assign data_nxt = last_edge ? (capture ? rx_shifted : rx_sh_r) :
                    (wr_data && !busy) ? w_byte_r : data_r;

  always_comb begin
    ctl1_nxt = ctl1_r;
    if (wr_ctl1) begin
      ctl1_nxt.clock_idle_polarity  = w_byte_r[fwsp_pkg::POL_BIT];
      ctl1_nxt.clock_edge_select    = w_byte_r[fwsp_pkg::EDGE_BIT];
      ctl1_nxt.bit_order_select     = w_byte_r[fwsp_pkg::ORDER_BIT];
      ctl1_nxt.select_pin_enable    = CFG_SEL_PIN && w_byte_r[fwsp_pkg::SELEN_BIT];
      ctl1_nxt.write_collision_flag = CFG_WCOL && w_byte_r[fwsp_pkg::WCOL_BIT];
      ctl1_nxt.transfer_done_flag   = w_byte_r[fwsp_pkg::DONE_BIT];
    end
    // hardware set wins over a software clear in the same cycle
    if (wcol_set) begin
      ctl1_nxt.write_collision_flag = 1'b1;
    end
    if (done_set) begin
      ctl1_nxt.transfer_done_flag = 1'b1;
    end
  end

  // ==========================================================
  // bus slave
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_ok_r   <= 1'b0;
      w_ok_r    <= 1'b0;
      aw_addr_r <= 4'h0;
      w_byte_r  <= 8'h00;
      w_lane_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= fwsp_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_ok_r   <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_ok_r   <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_ok_r  <= 1'b0;
        w_ok_r   <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? fwsp_pkg::RESP_OKAY : fwsp_pkg::RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= fwsp_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? fwsp_pkg::RESP_OKAY : fwsp_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl0_r <= '{clock_source_select: fwsp_pkg::CONTROL_0_RESET[7:5],
                  port_enable_bit:     fwsp_pkg::CONTROL_0_RESET[1]};
      ctl1_r <= fwsp_pkg::CONTROL_1_RESET[5:0];
      data_r <= fwsp_pkg::DATA_BUFFER_RESET;
    end else begin
      if (wr_ctl0) begin
        ctl0_r.clock_source_select <= w_byte_r[7:fwsp_pkg::SEL_LSB];
        ctl0_r.port_enable_bit     <= w_byte_r[fwsp_pkg::ENABLE_BIT];
      end
      ctl1_r <= ctl1_nxt;
      data_r <= data_nxt;
    end
  end

  // ==========================================================
  // shift engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_sh_r    <= 8'h00;
      rx_sh_r    <= 8'h00;
      edge_cnt_r <= 5'h00;
      m_busy_r   <= 1'b0;
      sck_r      <= 1'b1;
      sck_in_d_r <= 1'b1;
    end else begin
      sck_in_d_r <= serial_clock_in;
      if (!en || (is_slave && !selected)) begin
        // dropping enable or select aborts the byte without setting done
        edge_cnt_r <= 5'h00;
        m_busy_r   <= 1'b0;
        sck_r      <= idle_lvl;
        tx_sh_r    <= data_r;
      end else if (m_start) begin
        tx_sh_r  <= w_byte_r;
        m_busy_r <= 1'b1;
      end else if (sck_edge) begin
        if (capture) begin
          rx_sh_r <= rx_shifted;
        end else if (edge_cnt_r != 5'h00) begin
          tx_sh_r <= tx_shifted;
        end
        if (is_master) begin
          sck_r <= !sck_r;
        end
        if (last_edge) begin
          edge_cnt_r <= 5'h00;
          m_busy_r   <= 1'b0;
        end else begin
          edge_cnt_r <= edge_cnt_r + 5'h01;
        end
      end else if (!busy) begin
        sck_r   <= idle_lvl;
        tx_sh_r <= data_r;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_fast_start;
    m_start && (ctl0_r.clock_source_select == fwsp_pkg::SRC_DIV4);
  endsequence

  sequence s_first_edge;
    ##[1:3] (sck_edge && m_busy_r);
  endsequence

  AST_DIV4_FIRST_EDGE: assert property (
    s_fast_start |-> s_first_edge
  ) else $error("first serial clock edge late at fsys/4");

  AST_WCOL_ON_BUSY_WRITE: assert property (
    (wr_data && busy && CFG_WCOL) |=> ctl1_r.write_collision_flag
  ) else $error("collision flag not set on busy write");

  AST_BUSY_WRITE_IGNORED: assert property (
    (wr_data && busy && !last_edge) |=> (data_r == $past(data_r))
  ) else $error("data buffer changed by busy write");

  AST_MASTER_STARTS: assert property (
    m_start |=> (m_busy_r && !slave_select_out_n)
  ) else $error("master write did not start transfer");

  AST_DONE_AFTER_LAST: assert property (
    last_edge |=> (ctl1_r.transfer_done_flag && !busy)
  ) else $error("done flag missing after sixteenth edge");

  AST_IDLE_CLOCK_LEVEL: assert property (
    ($past(!busy && en) && !busy && $stable(ctl1_r.clock_idle_polarity))
      |-> (serial_clock_out == idle_lvl)
  ) else $error("serial clock not at idle level");

  AST_DISABLED_QUIET: assert property (
    (!en && !wr_ctl0) |=> (!m_busy_r && edge_cnt_r == 5'h00 && serial_clock_oe_n)
  ) else $error("disabled port still active");

  AST_SLAVE_ALWAYS_SEL: assert property (
    (is_slave && !sel_en) |-> (selected && !serial_output_oe_n)
  ) else $error("slave without select enable not selected");

  AST_RESERVED_ZERO: assert property (
    (ar_take && s_axi_araddr == fwsp_pkg::OFS_CONTROL_0) |=>
      (s_axi_rvalid && s_axi_rdata[4:2] == 3'h0 && s_axi_rdata[0] == 1'b0)
  ) else $error("reserved control bits read nonzero");

  AST_DONE_STICKY: assert property (
    (ctl1_r.transfer_done_flag && !wr_ctl1) |=> ctl1_r.transfer_done_flag
  ) else $error("done flag cleared without software write");

endmodule

// ==== shared/fwsp_pkg.sv ====
/*
  constants, field layouts and carrier types of the four-wire serial port.
  assumes a single 20 MHz system clock and byte-wide registers on 32-bit words.
*/
package fwsp_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] OFS_CONTROL_0   = 4'h0;
  localparam logic [3:0] OFS_CONTROL_1   = 4'h4;
  localparam logic [3:0] OFS_DATA_BUFFER = 4'h8;

  localparam logic [7:0] CONTROL_0_RESET   = 8'he0;
  localparam logic [7:0] CONTROL_1_RESET   = 8'h00;
  localparam logic [7:0] DATA_BUFFER_RESET = 8'h00;

  // ==========================================================
  // field positions
  localparam int SEL_LSB      = 5;
  localparam int ENABLE_BIT   = 1;
  localparam int POL_BIT      = 5;
  localparam int EDGE_BIT     = 4;
  localparam int ORDER_BIT    = 3;
  localparam int SELEN_BIT    = 2;
  localparam int WCOL_BIT     = 1;
  localparam int DONE_BIT     = 0;

  // ==========================================================
  // clock source codes
  localparam logic [2:0] SRC_DIV4   = 3'h0;
  localparam logic [2:0] SRC_DIV16  = 3'h1;
  localparam logic [2:0] SRC_DIV64  = 3'h2;
  localparam logic [2:0] SRC_SUB    = 3'h3;
  localparam logic [2:0] SRC_TIMER  = 3'h4;
  localparam logic [2:0] SRC_SLAVE  = 3'h5;

  // ==========================================================
  // timing: serial clock half periods in system cycles
  localparam int          SYS_CLK_HZ   = 20000000;
  localparam logic [5:0]  HALF_DIV4    = 6'h02;
  localparam logic [5:0]  HALF_DIV16   = 6'h08;
  localparam logic [5:0]  HALF_DIV64   = 6'h20;
  localparam logic [4:0]  EDGES_PER_XFER = 5'h10;

  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [2:0] clock_source_select;
    logic       port_enable_bit;
  } fwsp_ctl0_t;

  typedef struct packed {
    logic clock_idle_polarity;
    logic clock_edge_select;
    logic bit_order_select;
    logic select_pin_enable;
    logic write_collision_flag;
    logic transfer_done_flag;
  } fwsp_ctl1_t;

endpackage

// ==== rtl/fwsp_rate_gen.sv ====
/*
  master serial clock rate generator: one-cycle pulse per clock half period.
  assumes sub clock and timer match inputs are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
module fwsp_rate_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] src,
  input  wire logic       sub_clock_tick,
  input  wire logic       timer_period_match,
  output logic            half_tick
);

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] half_len;
  logic       div_tick;

  // ==========================================================
  // divider select
  assign half_len = (src == fwsp_pkg::SRC_DIV4)  ? fwsp_pkg::HALF_DIV4 :
                    (src == fwsp_pkg::SRC_DIV16) ? fwsp_pkg::HALF_DIV16 :
                                                   fwsp_pkg::HALF_DIV64;
  assign div_tick = run && (cnt_r == half_len - 6'h01);
  assign cnt_nxt  = (!run || div_tick) ? 6'h00 : cnt_r + 6'h01;

  // timer match toggles the line, so the clock runs at half the match rate
  assign half_tick = !run ? 1'b0 :
                     (src == fwsp_pkg::SRC_SUB)   ? sub_clock_tick :
                     (src == fwsp_pkg::SRC_TIMER) ? timer_period_match :
                     div_tick;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ==== testbench/fwsp_far_slave.sv ====
/*
  far-side serial slave model for the four-wire serial port bench.
  assumes clock and select come from the port in master mode, sampled on clk.
*/
`timescale 1ns/1ns
module fwsp_far_slave (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       msb_first,
  input  wire logic       cap_lead,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  // =====
  // shift state
  logic       sck_q;
  logic [4:0] n_edge;
  logic [2:0] ti;
  logic       held = 1'b0;
  logic       ss_q = 1'b1;
  wire  logic lead = ~n_edge[0];
  wire  logic cur  = tx_byte[msb_first ? 3'd7 - ti : ti];
  // a released line shows the inverse, so a stale bit never passes for data
  assign miso = ss_n ? ~held : cur;
  // the port lifts select with its last clock edge, so an edge counts by the select before it
  always @(posedge clk) begin
    sck_q <= sck;
    ss_q <= ss_n;
    if (!ss_n) held <= cur;
    if (!ss_q && sck != sck_q) begin
      n_edge <= n_edge + 5'd1;
      if (lead == cap_lead) rx_byte[msb_first ? 3'd7 - n_edge[3:1] : n_edge[3:1]] <= mosi;
      else if (n_edge != 5'd0) ti <= ti + 3'd1;
    end else if (ss_n) begin
      n_edge <= '0;
      ti <= '0;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
/*
  self-checking bench of the four-wire serial port: registers, master modes, slave mode.
  assumes the far-side slave model on the master pins and the tb acting as master otherwise.
*/
`timescale 1ns/1ns
module tb_top;
  // =====
  // pins and bench state
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, sub_tick = 0, tmr_tick = 0, tb_sdi = 0, sck_in = 1, ss_in_n = 1;
  logic        slv_mode = 0, msb = 0, caplead = 0, sck_q = 1, ss_q = 1;
  logic [3:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rv;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, sdo, sdo_oe_n, sck_out, sck_oe_n;
  logic        ss_out_n, ss_oe_n, far_miso;
  logic [7:0]  far_tx = 0, far_rx, c1, rxb, got;
  int          n_compared = 0, failures = 0, cyc = 0, tcnt = 0, n_sck = 0, gap = 0;
  int          last_gap = 0, ss_bad = 0, e0, b0, k;
  logic [2:0]  srcs [4] = '{fwsp_pkg::SRC_DIV16, fwsp_pkg::SRC_DIV64, fwsp_pkg::SRC_SUB,
                            fwsp_pkg::SRC_TIMER};
  logic [5:0]  halfs [4] = '{fwsp_pkg::HALF_DIV16, fwsp_pkg::HALF_DIV64, 6'h05, 6'h03};
  wire  logic  sdi = slv_mode ? tb_sdi : far_miso;

  always #25 clk = ~clk;

  fwsp_top i_fwsp_top (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sub_clock_tick(sub_tick), .timer_period_match(tmr_tick), .serial_input_line(sdi),
    .serial_output_line(sdo), .serial_output_oe_n(sdo_oe_n), .serial_clock_in(sck_in),
    .serial_clock_out(sck_out), .serial_clock_oe_n(sck_oe_n), .slave_select_in_n(ss_in_n),
    .slave_select_out_n(ss_out_n), .slave_select_oe_n(ss_oe_n));

  fwsp_far_slave i_fwsp_far_slave (.clk(clk), .sck(sck_out), .ss_n(ss_out_n), .mosi(sdo),
    .msb_first(msb), .cap_lead(caplead), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

  // =====
  // ticks, link monitor, timeout
  always @(posedge clk) begin
    tcnt <= tcnt + 1;
    sub_tick <= (tcnt % 5 == 0);
    tmr_tick <= (tcnt % 3 == 0);
    cyc <= cyc + 1;
    sck_q <= sck_out;
    ss_q <= ss_out_n;
    gap <= gap + 1;
    if (rst_n && sck_out !== sck_q) begin
      n_sck <= n_sck + 1;
      last_gap <= gap;
      gap <= 1;
      // select as it stood before the edge; it rises together with the last one
      if (ss_q !== 1'b0) ss_bad <= ss_bad + 1;
    end
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end

  // =====
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw, hb;
    pa = 1;
    pw = 1;
    hb = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    while (!hb) begin
      @(negedge clk);
      hb = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    h = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!h) begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
    end
    arvalid <= 0;
    h = 0;
    while (!h) begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    rd(a, rv, rs);
    chk(nm, rv, {24'h0, e});
    chk("rresp", rs, fwsp_pkg::RESP_OKAY);
  endtask

  // master byte against the far slave; coll writes again while busy
  task automatic mxfer(input logic [2:0] src, input logic [7:0] c, input logic [7:0] tx,
                       input logic [7:0] fx, input logic [5:0] half, input logic coll);
    msb <= c[3];
    caplead <= c[4];
    far_tx <= fx;
    wr(fwsp_pkg::OFS_CONTROL_1, c, rs);
    wr(fwsp_pkg::OFS_CONTROL_0, {src, 5'b00010}, rs);
    e0 = n_sck;
    b0 = ss_bad;
    wr(fwsp_pkg::OFS_DATA_BUFFER, tx, rs);
    chk("data bresp", rs, fwsp_pkg::RESP_OKAY);
    if (coll) wr(fwsp_pkg::OFS_DATA_BUFFER, ~tx, rs);
    rv = 0;
    for (k = 0; k < 400 && !rv[0]; k++) rd(fwsp_pkg::OFS_CONTROL_1, rv, rs);
    chk("ctl1 after", rv, {24'h0, c | {6'h0, coll, 1'b1}});
    rchk(fwsp_pkg::OFS_DATA_BUFFER, fx, "rx byte");
    chk("far rx", far_rx, tx);
    chk("edges", n_sck - e0, 16);
    chk("half period", last_gap, {26'h0, half});
    chk("idle level", sck_out, !c[5]);
    chk("select oe", ss_oe_n, !c[2]);
    chk("clock unselected", ss_bad - b0, 0);
  endtask

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // =====
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rchk(fwsp_pkg::OFS_CONTROL_0, fwsp_pkg::CONTROL_0_RESET, "ctl0 reset");
    rchk(fwsp_pkg::OFS_CONTROL_1, fwsp_pkg::CONTROL_1_RESET, "ctl1 reset");
    rchk(fwsp_pkg::OFS_DATA_BUFFER, fwsp_pkg::DATA_BUFFER_RESET, "data reset");
    wr(fwsp_pkg::OFS_CONTROL_0, 8'hff, rs);
    rchk(fwsp_pkg::OFS_CONTROL_0, 8'he2, "ctl0 unused");
    wr(fwsp_pkg::OFS_CONTROL_1, 8'hff, rs);
    rchk(fwsp_pkg::OFS_CONTROL_1, 8'h3f, "ctl1 unused");
    wr(fwsp_pkg::OFS_CONTROL_1, 8'h00, rs);
    rchk(fwsp_pkg::OFS_CONTROL_1, 8'h00, "flags cleared");
    wr(4'hc, 8'h55, rs);
    chk("unmapped bresp", rs, fwsp_pkg::RESP_SLVERR);
    rd(4'hc, rv, rs);
    chk("unmapped rresp", rs, fwsp_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      c1 = {2'b00, i[2:0], 3'b100};
      mxfer(fwsp_pkg::SRC_DIV4, c1, 8'hb1 ^ i[7:0], 8'h35 ^ i[7:0], fwsp_pkg::HALF_DIV4, 0);
    end
    for (int j = 0; j < 4; j++)
      mxfer(srcs[j], 8'h08, 8'h4b + j[7:0], 8'h92 ^ j[7:0], halfs[j], j == 0);
    wr(fwsp_pkg::OFS_CONTROL_1, 8'h00, rs);
    wr(fwsp_pkg::OFS_CONTROL_0, {fwsp_pkg::SRC_DIV4, 5'b00000}, rs);
    e0 = n_sck;
    wr(fwsp_pkg::OFS_DATA_BUFFER, 8'h77, rs);
    repeat (40) @(posedge clk);
    chk("disabled edges", n_sck - e0, 0);
    chk("disabled clock oe", sck_oe_n, 1'b1);
    rchk(fwsp_pkg::OFS_CONTROL_1, 8'h00, "disabled done");
    slv_mode <= 1;
    for (int s = 0; s < 2; s++) begin
      rxb = 8'h2d ^ s[7:0];
      wr(fwsp_pkg::OFS_CONTROL_1, {5'b00001, s[0], 2'b00}, rs);
      wr(fwsp_pkg::OFS_CONTROL_0, {fwsp_pkg::SRC_SLAVE, 5'b00010}, rs);
      wr(fwsp_pkg::OFS_DATA_BUFFER, 8'h6a ^ s[7:0], rs);
      ss_in_n <= ~s[0];
      repeat (2) @(posedge clk);
      for (int b = 7; b >= 0; b--) begin
        tb_sdi <= rxb[b];
        sck_in <= 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        got[b] = sdo;
        @(posedge clk);
        sck_in <= 1;
        repeat (4) @(posedge clk);
      end
      rchk(fwsp_pkg::OFS_CONTROL_1, {5'b00001, s[0], 2'b01}, "slave done");
      rchk(fwsp_pkg::OFS_DATA_BUFFER, rxb, "slave rx");
      chk("slave tx", got, 8'h6a ^ s[7:0]);
      chk("slave sdo oe", sdo_oe_n, 1'b0);
      ss_in_n <= 1;
    end
    wrap_up();
  end
endmodule
